// >>> sim/pwm_cmp_model.sv
// Partner model: PWM waveform source and the two offset comparators.
// Assumes the block's calibration state is fed back to it each cycle.
`default_nettype none
module pwm_cmp_model
   import ocp_gate_pkg::*;
#(
   parameter int AMP_THR = 23,
   parameter int CMP_THR = 11
)
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // Calibration state from the block
   input  wire chan_cal_t chan_cal [2],
   // Toward the block
   output pwm_set_t       pwm_in,
   output logic [1:0]     compare_raw
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end
   // Low bits toggle each cycle, high bits every other, so a stuck
   // output cannot match for long
   assign pwm_in = {phase[1], ~phase[1], phase[0], ~phase[0]};
   // The trim flips the comparator once it passes the offset point
   always_comb
   begin
      for (int n = 0; n < 2; n++)
      begin
         if (chan_cal[n].amp_cal_mode_bit)
            compare_raw[n] = int'(chan_cal[n].amp_trim_field) >= AMP_THR;
         else
            compare_raw[n] = int'(chan_cal[n].cmp_trim_field) >= CMP_THR;
      end
   end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the over-current output gating block.
// Assumes this bench is the only AHB-Lite master, partner model beside.
`default_nettype none
`include "ocp_gate_defs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench
   import ocp_gate_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AMP_T = 23;
   localparam int CMP_T = 11;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0;
   logic        hreadyout, hresp, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0, det = 0, cmp, ubuf, csw;
   logic [2:0]  hsize = 3'h2;
   logic [2:0]  gain [2];
   pwm_set_t    pwm_in, pwm_out;
   ocp_mode_t   mode [2];
   chan_cal_t   cal [2];
   int          n_mismatch = 0, checked = 0;
   always #5 clk = ~clk;
   ocp_output_gate dut_u (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .overcurrent_detect(det),
      .compare_raw(cmp), .pwm_in(pwm_in), .pwm_out(pwm_out),
      .channel_mode_field(mode), .gain_select_field(gain),
      .unity_buffer(ubuf), .calibration_switch(csw), .chan_cal(cal),
      .irq(irq));
   pwm_cmp_model #(.AMP_THR(AMP_T), .CMP_THR(CMP_T)) model_u (.clk(clk),
      .rst(rst), .chan_cal(cal), .pwm_in(pwm_in), .compare_raw(cmp));
   task complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Waits for hready at a rising edge; a stuck slave ends the run
   task rdy;
      int n;
      n = 0;
      do begin @(posedge clk); n++; end
      while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1)
      begin
         n_mismatch++;
         complete_run;
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      rdy;
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      rdy;
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
                     input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      `CHK(nm, e, r & m)
      `CHK("hresp", 1'b0, hresp)
   endtask
   task reset_values;
      rd("enable", `OFS_OC_ENABLE, 32'hff, 32'h0);
      rd("forced", `OFS_FORCED_STATE, 32'hf, 32'h0);
      rd("ctrl", `OFS_CH0_CTRL, 32'h1f, 32'h0);
      rd("cal", `OFS_CH1_CAL, 32'h7fff, 32'h1020);
      // Both cal bits set on channel 1: the switch must stay open later
      wr(`OFS_CH1_CAL, 32'h356a);
      rd("cal rw", `OFS_CH1_CAL, 32'h7fff, 32'h356a);
      rd("unmapped", 12'h040, 32'hffffffff, 32'h0);
      wr(`OFS_OC_ENABLE, 32'ha5);
      rd("enable rw", `OFS_OC_ENABLE, 32'hff, 32'ha5);
   endtask
   // Each enable bit alone, against every detector combination and release
   task gating;
      logic [3:0] e;
      wr(`OFS_FORCED_STATE, 32'ha);
      for (int b = 0; b < 8; b++)
      begin
         wr(`OFS_OC_ENABLE, 32'h1 << b);
         for (int d = 0; d < 5; d++)
         begin
            det <= d[1:0];
            @(posedge clk);
            #1;
            e = pwm_in;
            if (d[b / 4]) e[b % 4] = b[0];
            `CHK("pwm_out", e, pwm_out)
            @(posedge clk);
         end
      end
   endtask
   task modes;
      for (int m = 0; m < 4; m++)
         for (int g = 0; g < 8; g += 7)
         begin
            wr(`OFS_CH1_CTRL, 32'(m | (g << 2)));
            #1;
            `CHK("mode", m[1:0], mode[1])
            `CHK("gain", g[2:0], gain[1])
            `CHK("unity", (m == 1 && g == 0), ubuf[1])
            `CHK("switch", 1'b0, csw[1])
            @(posedge clk);
         end
   endtask
   task interrupts;
      // Gating left both events pending; start from a clean status
      wr(`OFS_IRQ_STATUS, 32'h3);
      rd("status clear", `OFS_IRQ_STATUS, 32'h3, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h1);
      rd("mask", `OFS_IRQ_MASK, 32'h3, 32'h1);
      `CHK("irq idle", 1'b0, irq)
      det <= 2'b01;
      repeat (3) @(posedge clk);
      det <= 2'b10;
      #1;
      `CHK("irq on", 1'b1, irq)
      repeat (3) @(posedge clk);
      rd("live", `OFS_LIVE_STATUS, 32'hf, 32'h2);
      rd("status", `OFS_IRQ_STATUS, 32'h3, 32'h3);
      wr(`OFS_IRQ_STATUS, 32'h1);
      det <= 2'b00;
      #1;
      `CHK("irq masked", 1'b0, irq)
      @(posedge clk);
      rd("status left", `OFS_IRQ_STATUS, 32'h3, 32'h2);
      wr(`OFS_IRQ_STATUS, 32'h2);
   endtask
   // Software offset sweep on channel 0: up from zero, down from full scale
   task automatic sweep(input int lsb, w, mbit, thr);
      logic [31:0] r, k;
      int          t, v1, v2;
      k = 32'h1 << mbit;
      wr(`OFS_CH0_CTRL, 32'h3);
      wr(`OFS_CH0_CAL, k);
      xfer(1'b0, `OFS_CH0_CAL, 32'h0, r);
      `CHK("cmp low", 1'b0, r[`CAL_CMP_OUT_BIT])
      for (t = 1; t < (1 << w); t++)
      begin
         wr(`OFS_CH0_CAL, k | (32'(t) << lsb));
         xfer(1'b0, `OFS_CH0_CAL, 32'h0, r);
         if (r[`CAL_CMP_OUT_BIT] !== 1'b0) break;
      end
      v1 = t;
      wr(`OFS_CH0_CAL, k | (32'((1 << w) - 1) << lsb));
      xfer(1'b0, `OFS_CH0_CAL, 32'h0, r);
      `CHK("cmp high", 1'b1, r[`CAL_CMP_OUT_BIT])
      for (t = (1 << w) - 2; t >= 0; t--)
      begin
         wr(`OFS_CH0_CAL, k | (32'(t) << lsb));
         xfer(1'b0, `OFS_CH0_CAL, 32'h0, r);
         if (r[`CAL_CMP_OUT_BIT] !== 1'b1) break;
      end
      v2 = t;
      `CHK("first", thr, v1)
      `CHK("second", thr - 1, v2)
      wr(`OFS_CH0_CAL, k | (32'((v1 + v2) / 2) << lsb));
      #1;
      `CHK("switch", (mbit == `CAL_CMP_MODE_BIT), csw[0])
      @(posedge clk);
      rd("trim", `OFS_CH0_CAL, ((32'h1 << w) - 1) << lsb,
         32'(thr - 1) << lsb);
   endtask
   // Mid-run reset must bring back the power-on enable, channel 0 calibration and switch values
   task reset_again;
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd("enable reset", `OFS_OC_ENABLE, 32'hff, 32'h0);
      rd("cal reset", `OFS_CH0_CAL, 32'h7fff, 32'h1020);
      #1;
      `CHK("switch reset", 1'b0, csw[0])
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reset_values;
      gating;
      modes;
      interrupts;
      sweep(`CAL_AMP_TRIM_LSB, 6, `CAL_AMP_MODE_BIT, AMP_T);
      sweep(`CAL_CMP_TRIM_LSB, 5, `CAL_CMP_MODE_BIT, CMP_T);
      reset_again;
      complete_run;
   end
endmodule
`default_nettype wire

// >>> verilog/ocp_gate_defs.svh
// Register offsets, field positions and reset values of the over-current
// output gating block. Included by the testbench and the design file.
`ifndef OCP_GATE_DEFS_SVH
`define OCP_GATE_DEFS_SVH

`define OFS_OC_ENABLE     12'h000
`define OFS_FORCED_STATE  12'h004
`define OFS_CH0_CTRL      12'h008
`define OFS_CH1_CTRL      12'h00c
`define OFS_CH0_CAL       12'h010
`define OFS_CH1_CAL       12'h014
`define OFS_IRQ_STATUS    12'h018
`define OFS_IRQ_MASK      12'h01c
`define OFS_LIVE_STATUS   12'h020

`define RST_OC_ENABLE     8'h00
`define RST_FORCED_STATE  4'h0
`define RST_AMP_TRIM      6'h20
`define RST_CMP_TRIM      5'h10

// Channel control word: [1:0] mode, [4:2] gain select
`define CTRL_MODE_LSB     0
`define CTRL_GAIN_LSB     2
// Calibration word: [5:0] amp trim, [6] amp cal mode,
// [12:8] cmp trim, [13] cmp cal mode, [15] compare output (read only)
`define CAL_AMP_TRIM_LSB  0
`define CAL_AMP_MODE_BIT  6
`define CAL_CMP_TRIM_LSB  8
`define CAL_CMP_MODE_BIT  13
`define CAL_CMP_OUT_BIT   15

`define GAIN_UNITY        3'h0
`define HTRANS_NONSEQ     2'h2
`define ADDR_DEC_BITS     12

`endif

// >>> verilog/ocp_gate_pkg.sv
// Types shared by the over-current output gating block.
// Assumes ocp_gate_defs.svh is on the include path.
`default_nettype none
package ocp_gate_pkg;
   typedef enum logic [1:0]
   {
      MODE_OFF,
      MODE_NONINV,
      MODE_INV,
      MODE_CAL
   } ocp_mode_t;

   // One channel's trim and calibration state
   typedef struct packed
   {
      logic       cmp_cal_mode_bit;
      logic [4:0] cmp_trim_field;
      logic       amp_cal_mode_bit;
      logic [5:0] amp_trim_field;
   } chan_cal_t;

   // Four PWM outputs, bit order pair1 low, pair1 high, pair0 low, pair0 high
   typedef struct packed
   {
      logic pair1_low;
      logic pair1_high;
      logic pair0_low;
      logic pair0_high;
   } pwm_set_t;
endpackage
`default_nettype wire

// >>> verilog/ocp_output_gate.sv
// Over-current output gating, channel mode and calibration control with
// an AHB-Lite register slave. Assumes detector and compare inputs are
// already synchronous to clk; analog paths live outside.
`default_nettype none
`include "ocp_gate_defs.svh"
module ocp_output_gate
   import ocp_gate_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Detectors and comparators
   input  wire logic [1:0]  overcurrent_detect,
   input  wire logic [1:0]  compare_raw,
   // PWM path
   input  wire pwm_set_t    pwm_in,
   output pwm_set_t         pwm_out,
   // Analog control
   output ocp_mode_t        channel_mode_field [2],
   output logic [2:0]       gain_select_field [2],
   output logic [1:0]       unity_buffer,
   output logic [1:0]       calibration_switch,
   output chan_cal_t        chan_cal [2],
   // Interrupt
   output logic             irq
);
   logic [7:0]  oc_enable;
   pwm_set_t    output_forced_state_reg;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic [1:0]  oc_prev;
   logic [11:0] addr_q;
   logic        wr_q;

   // Address phase capture; data phase always zero wait
   wire addr_phase = hsel && hready && htrans == `HTRANS_NONSEQ;
   wire wr_hit     = wr_q;
   wire [1:0] oc_rise = overcurrent_detect & ~oc_prev;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         addr_q <= 12'h000;
         wr_q   <= 1'b0;
      end
      else
      begin
         addr_q <= haddr[`ADDR_DEC_BITS-1:0];
         wr_q   <= addr_phase && hwrite;
      end

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         oc_enable               <= `RST_OC_ENABLE;
         output_forced_state_reg <= `RST_FORCED_STATE;
         irq_mask                <= 2'h0;
      end
      else if (wr_hit)
      begin
         if (addr_q == `OFS_OC_ENABLE)
            oc_enable <= hwdata[7:0];
         if (addr_q == `OFS_FORCED_STATE)
            output_forced_state_reg <= hwdata[3:0];
         if (addr_q == `OFS_IRQ_MASK)
            irq_mask <= hwdata[1:0];
      end

   // Sticky over-current events; a new rising edge beats the clear
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         irq_status <= 2'h0;
         oc_prev    <= 2'h0;
      end
      else
      begin
         oc_prev    <= overcurrent_detect;
         irq_status <= (irq_status & ~((wr_hit && addr_q == `OFS_IRQ_STATUS)
                       ? hwdata[1:0] : 2'h0)) | oc_rise;
      end

   assign irq = |(irq_status & irq_mask);

   // Per-channel mode, gain and calibration registers
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         wire [11:0] ctrl_ofs = ch ? `OFS_CH1_CTRL : `OFS_CH0_CTRL;
         wire [11:0] cal_ofs  = ch ? `OFS_CH1_CAL : `OFS_CH0_CAL;
         always_ff @(posedge clk or posedge rst)
            if (rst)
            begin
               channel_mode_field[ch] <= MODE_OFF;
               gain_select_field[ch]  <= 3'h0;
               chan_cal[ch]           <= {1'b0, `RST_CMP_TRIM, 1'b0,
                                          `RST_AMP_TRIM};
            end
            else if (wr_hit)
            begin
               if (addr_q == ctrl_ofs)
               begin
                  channel_mode_field[ch] <=
                     ocp_mode_t'(hwdata[`CTRL_MODE_LSB +: 2]);
                  gain_select_field[ch] <= hwdata[`CTRL_GAIN_LSB +: 3];
               end
               // Trims stay writable in every mode so software can step
               // them one at a time during a sweep
               if (addr_q == cal_ofs)
                  chan_cal[ch] <= {hwdata[`CAL_CMP_MODE_BIT],
                                   hwdata[`CAL_CMP_TRIM_LSB +: 5],
                                   hwdata[`CAL_AMP_MODE_BIT],
                                   hwdata[`CAL_AMP_TRIM_LSB +: 6]};
            end
         assign unity_buffer[ch] = channel_mode_field[ch] == MODE_NONINV &&
            gain_select_field[ch] == `GAIN_UNITY;
         // Switch closes only for comparator calibration; open otherwise
         assign calibration_switch[ch] = channel_mode_field[ch] == MODE_CAL
            && chan_cal[ch].cmp_cal_mode_bit
            && !chan_cal[ch].amp_cal_mode_bit;
      end
   endgenerate

   // Output gating: each output forced if any enabling detector fires
   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_gate
         wire force_out = (oc_enable[b] && overcurrent_detect[0]) ||
                          (oc_enable[b+4] && overcurrent_detect[1]);
         // Combinational so the output follows the detector with no lag
         assign pwm_out[b] = force_out ? output_forced_state_reg[b]
                                       : pwm_in[b];
      end
   endgenerate

   // Read mux
   wire [31:0] cal_rd [2];
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_rd
         assign cal_rd[ch] = {16'h0000, compare_raw[ch], 1'b0,
            chan_cal[ch].cmp_cal_mode_bit, chan_cal[ch].cmp_trim_field,
            1'b0, chan_cal[ch].amp_cal_mode_bit,
            chan_cal[ch].amp_trim_field};
      end
   endgenerate

   logic [31:0] next_rdata;
   always_comb
   begin
      unique case (haddr[`ADDR_DEC_BITS-1:0])
         `OFS_OC_ENABLE:    next_rdata = {24'h0, oc_enable};
         `OFS_FORCED_STATE: next_rdata = {28'h0, output_forced_state_reg};
         `OFS_CH0_CTRL:     next_rdata = {27'h0, gain_select_field[0],
                                          channel_mode_field[0]};
         `OFS_CH1_CTRL:     next_rdata = {27'h0, gain_select_field[1],
                                          channel_mode_field[1]};
         `OFS_CH0_CAL:      next_rdata = cal_rd[0];
         `OFS_CH1_CAL:      next_rdata = cal_rd[1];
         `OFS_IRQ_STATUS:   next_rdata = {30'h0, irq_status};
         `OFS_IRQ_MASK:     next_rdata = {30'h0, irq_mask};
         `OFS_LIVE_STATUS:  next_rdata = {28'h0, calibration_switch,
                                          overcurrent_detect};
         default:           next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (addr_phase && !hwrite)
         hrdata <= next_rdata;

   // Checks
   a_force_level: assert property (@(posedge clk) disable iff (rst)
      (oc_enable[0] && overcurrent_detect[0])
      |-> pwm_out[0] == output_forced_state_reg[0])
      else $error("forced level not applied");
   a_pass_through: assert property (@(posedge clk) disable iff (rst)
      (oc_enable[3] == 1'b0 && oc_enable[7] == 1'b0)
      |-> pwm_out[3] == pwm_in[3])
      else $error("disabled output was gated");
   a_release_pwm: assert property (@(posedge clk) disable iff (rst)
      ($fell(overcurrent_detect[1]) && !overcurrent_detect[0])
      |-> pwm_out == pwm_in)
      else $error("output stuck after release");
   a_enable_write: assert property (@(posedge clk) disable iff (rst)
      (wr_hit && addr_q == `OFS_OC_ENABLE) |=> oc_enable == $past(hwdata[7:0]))
      else $error("enable register not written");
   a_mode_write: assert property (@(posedge clk) disable iff (rst)
      (wr_hit && addr_q == `OFS_CH0_CTRL)
      |=> channel_mode_field[0] == $past(hwdata[1:0]))
      else $error("mode not written");
   // Judged against the written word, not the decode it guards
   a_unity_buffer: assert property (@(posedge clk) disable iff (rst)
      (wr_hit && addr_q == `OFS_CH0_CTRL)
      |=> unity_buffer[0] == ($past(hwdata[4:0]) == 5'h01))
      else $error("unity buffer wrong");
   a_cal_switch: assert property (@(posedge clk) disable iff (rst)
      channel_mode_field[1] != MODE_CAL |-> !calibration_switch[1])
      else $error("switch closed outside calibration");
   a_compare_read: assert property (@(posedge clk) disable iff (rst)
      (addr_phase && !hwrite && haddr[11:0] == `OFS_CH0_CAL)
      |=> hrdata[`CAL_CMP_OUT_BIT] == $past(compare_raw[0]))
      else $error("compare bit misread");
   a_trim_write: assert property (@(posedge clk) disable iff (rst)
      (wr_hit && addr_q == `OFS_CH1_CAL)
      |=> chan_cal[1].amp_trim_field == $past(hwdata[5:0]))
      else $error("trim not written");
   // A clear written in the cycle of a new event must not lose it
   a_event_wins: assert property (@(posedge clk) disable iff (rst)
      oc_rise[0] |=> irq_status[0])
      else $error("event lost to clear");

   c_forced: cover property (@(posedge clk) pwm_out != pwm_in);
   c_cal_sw: cover property (@(posedge clk) calibration_switch[0]);
   c_irq:    cover property (@(posedge clk) $rose(irq));
endmodule
`default_nettype wire
